//--- core/sqd_cfg.svh
// constants for the squib serial command interface
// assumes one include per compile unit; guarded against double inclusion
// How it works
// - frames shift an 8-bit register in and out, most significant bit first
// - reply byte of a frame carries the previous command's result
// - no-operation clears every diagnostic mode; pending reply still goes out
// - undefined command codes behave exactly like no-operation
// - received command acts only when chip select rises at frame end
// - a diagnostic mode lasts only until the next valid command frame
// - echo code 96 makes the next frame return 69
// - reply bits without diagnostic content are zero
// - frames of seven or fewer, or nine or more, bits are ignored; here they drop a pending arm; a clockless one after a valid frame reruns it
// - second programming byte is no-operation while any driver fires
// - programming bytes must be consecutive frames, else no-operation
// - input sampled on rising clock, output changes on falling clock
// - clock level at chip select fall selects serial mode for the frame
// - serial output is high impedance while chip select is high
// - reply bit 7 to identity query is the channel-count strap
// - continuity result clears once shifted out on next valid frame
// - reply after continuity command reports all four low-side drivers
// - reset low disables functions and clears all shift registers
// - results loaded for shifting out; shifted byte latched at select rise
`ifndef SQD_CFG_SVH
`define SQD_CFG_SVH

`define SQD_FRAME_BITS 4'h8
`define SQD_CNT_SAT 4'h9
`define SQD_IDX_LAST 3'h7
`define SQD_SYNC_STAGES 3

`define SQD_CMD_NOP 8'h00
`define SQD_CMD_ECHO 8'h96
`define SQD_ECHO_REPLY 8'h69
`define SQD_CMD_ID 8'hC8
`define SQD_CMD_CONT 8'hC2
`define SQD_CMD_FORCE 8'hC1
`define SQD_CMD_SENSE 8'hE8
`define SQD_CMD_ARM_1 8'hA0
`define SQD_CMD_ARM_2 8'hA1
`define SQD_CMD_ARM_ALL 8'hA2
`define SQD_ARM_HI 4'hA
`define SQD_FIRE_HI 4'h5

`define SQD_MASK_1 4'h3
`define SQD_MASK_2 4'hC
`define SQD_MASK_ALL 4'hF

`define SQD_REPLY_RST 8'h00
`define SQD_FIRE_RST 4'h0

`endif

//--- core/sqd_pkg.sv
// types shared by the squib serial command interface
// assumes sqd_cfg.svh supplies the numeric constants
package sqd_pkg;
	typedef logic [7:0] sqd_byte_t;
	typedef logic [3:0] sqd_nib_t;
	typedef enum logic [2:0] {
		SQD_CLS_NOP,
		SQD_CLS_ECHO,
		SQD_CLS_ID,
		SQD_CLS_CONT,
		SQD_CLS_DIAG,
		SQD_CLS_ARM,
		SQD_CLS_FIRE
	} sqd_cls_t;
endpackage : sqd_pkg

//--- core/sqd_link_if.sv
// carrier between the link shifter and the command core
// reply is held still while selected; rx and cnt still while deselected
`timescale 1ns/1ps
interface sqd_link_if;
	logic [7:0] reply;
	logic [7:0] rx;
	logic [3:0] cnt;
	modport link (input reply, output rx, output cnt);
	modport core (output reply, input rx, input cnt);
endinterface : sqd_link_if

//--- core/sqd_link.sv
// serial shifter running on the master's serial clock
// assumes chip select meets setup to the serial clock edges
`timescale 1ns/1ps
`include "sqd_cfg.svh"
module sqd_link (
	input wire logic serial_clk,
	input wire logic rstn,
	input wire logic chip_select_n,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe,
	sqd_link_if.link lk
);
	import sqd_pkg::*;

	logic [7:0] rx_q, rx_d;
	logic [3:0] cnt_q, cnt_d;
	logic fresh_q;
	logic [2:0] idx_q, idx_d;
	logic clr_n;

	// deselect restarts the frame bookkeeping
	assign clr_n = rstn & ~chip_select_n;

	always_comb begin
		rx_d = rx_q;
		cnt_d = cnt_q;
		if (!chip_select_n) begin
			rx_d = {rx_q[6:0], serial_in_pin};
			if (fresh_q)
				cnt_d = 4'h1;
			else if (cnt_q != `SQD_CNT_SAT)
				cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge serial_clk or negedge rstn) begin
		if (!rstn) begin
			rx_q <= `SQD_REPLY_RST;
			cnt_q <= 4'h0;
		end else begin
			rx_q <= rx_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge serial_clk or negedge clr_n) begin
		if (!clr_n)
			fresh_q <= 1'b1;
		else
			fresh_q <= 1'b0;
	end

	// a falling edge before the first rise (clock idle high) keeps bit 7
	always_comb begin
		idx_d = idx_q;
		if (!fresh_q && idx_q != `SQD_IDX_LAST)
			idx_d = idx_q + 3'h1;
	end

	always_ff @(negedge serial_clk or negedge clr_n) begin
		if (!clr_n)
			idx_q <= 3'h0;
		else
			idx_q <= idx_d;
	end

	assign serial_out_pin = lk.reply[`SQD_IDX_LAST - idx_q];
	assign serial_out_oe = ~chip_select_n;
	assign lk.rx = rx_q;
	assign lk.cnt = cnt_q;
endmodule : sqd_link

//--- core/sqd_core.sv
// command interpreter and reply sequencing for the squib driver link
// assumes analog diagnostics outside; serial clock is a second domain
`timescale 1ns/1ps
`include "sqd_cfg.svh"
module sqd_core #(
	parameter logic TWO_CHANNEL = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic serial_clk,
	input wire logic chip_select_n,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire sqd_pkg::sqd_nib_t low_side_cont_in,
	input wire sqd_pkg::sqd_byte_t diag_result_in,
	output sqd_pkg::sqd_byte_t diag_cmd,
	output logic diag_active,
	output sqd_pkg::sqd_nib_t squib_fire
);
	import sqd_pkg::*;

	sqd_link_if lk_if ();

	sqd_link u_link (
		.serial_clk(serial_clk),
		.rstn(rstn),
		.chip_select_n(chip_select_n),
		.serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe),
		.lk(lk_if.link)
	);

	// sorts a received byte; codes not listed fall through to no-op, except high nibble 5 (fire)
	function automatic sqd_cls_t sqd_classify(input sqd_byte_t c);
		sqd_cls_t k;
		k = SQD_CLS_NOP;
		case (c)
			`SQD_CMD_ECHO: k = SQD_CLS_ECHO;
			`SQD_CMD_ID: k = SQD_CLS_ID;
			`SQD_CMD_CONT: k = SQD_CLS_CONT;
			`SQD_CMD_ARM_1, `SQD_CMD_ARM_2, `SQD_CMD_ARM_ALL: k = SQD_CLS_ARM;
			8'h70, 8'h71, 8'h72, 8'h73, 8'h79, `SQD_CMD_FORCE, 8'hC3, 8'hC9,
			8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hE0, 8'hE1, 8'hE2, 8'hE3,
			`SQD_CMD_SENSE, 8'hE9, 8'hF0, 8'hF1, 8'hF2, 8'hF3:
				k = SQD_CLS_DIAG;
			default: begin
				if (c[7:4] == `SQD_FIRE_HI)
					k = SQD_CLS_FIRE;
				else
					k = SQD_CLS_NOP;
			end
		endcase
		return k;
	endfunction : sqd_classify

	// chip select seen in this domain: three stages, change on agreement
	logic [2:0] cs_s_q, cs_s_d;
	logic cs_lvl_q, cs_lvl_d;
	logic frame_end;

	always_comb begin
		cs_s_d = {cs_s_q[1:0], chip_select_n};
		cs_lvl_d = cs_lvl_q;
		if (cs_s_q[1] == cs_s_q[2])
			cs_lvl_d = cs_s_q[2];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cs_s_q <= 3'h7;
			cs_lvl_q <= 1'b1;
		end else begin
			cs_s_q <= cs_s_d;
			cs_lvl_q <= cs_lvl_d;
		end
	end

	// link words are still by now: no serial edges while deselected
	assign frame_end = cs_lvl_d & ~cs_lvl_q;

	// command state
	sqd_byte_t reply_q, reply_d;
	sqd_byte_t diag_cmd_q, diag_cmd_d;
	logic diag_act_q, diag_act_d;
	logic pend_q, pend_d;
	logic arm_q, arm_d;
	sqd_nib_t mask_q, mask_d;
	sqd_nib_t fire_q, fire_d;
	sqd_cls_t cls;
	logic frame_ok;

	assign frame_ok = (lk_if.cnt == `SQD_FRAME_BITS);

	always_comb begin
		reply_d = reply_q;
		diag_cmd_d = diag_cmd_q;
		diag_act_d = diag_act_q;
		pend_d = pend_q;
		arm_d = arm_q;
		mask_d = mask_q;
		fire_d = fire_q;
		cls = sqd_classify(lk_if.rx);
		// a fire byte only counts right after an arm and while no driver fires
		if (cls == SQD_CLS_FIRE) begin
			if (!arm_q || fire_q != `SQD_FIRE_RST)
				cls = SQD_CLS_NOP;
		end
		// diagnostic result tracks the analog side until the next select
		if (pend_q && cs_lvl_q)
			reply_d = diag_result_in;
		if (frame_end) begin
			arm_d = 1'b0;
			if (frame_ok) begin
				diag_act_d = 1'b0;
				diag_cmd_d = `SQD_CMD_NOP;
				pend_d = 1'b0;
				reply_d = `SQD_REPLY_RST;
				case (cls)
					SQD_CLS_ECHO: reply_d = `SQD_ECHO_REPLY;
					SQD_CLS_ID: reply_d = {TWO_CHANNEL, 7'h00};
					SQD_CLS_CONT: begin
						reply_d = {4'h0, low_side_cont_in};
						diag_act_d = 1'b1;
						diag_cmd_d = lk_if.rx;
					end
					SQD_CLS_DIAG: begin
						diag_act_d = 1'b1;
						diag_cmd_d = lk_if.rx;
						pend_d = 1'b1;
					end
					SQD_CLS_ARM: begin
						arm_d = 1'b1;
						reply_d = lk_if.rx;
						case (lk_if.rx)
							`SQD_CMD_ARM_1: mask_d = `SQD_MASK_1;
							`SQD_CMD_ARM_2: mask_d = `SQD_MASK_2;
							default: mask_d = `SQD_MASK_ALL;
						endcase
					end
					SQD_CLS_FIRE: begin
						reply_d = lk_if.rx;
						fire_d = (fire_q & ~mask_q) | (lk_if.rx[3:0] & mask_q);
					end
					default: reply_d = `SQD_REPLY_RST;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reply_q <= `SQD_REPLY_RST;
			diag_cmd_q <= `SQD_CMD_NOP;
			diag_act_q <= 1'b0;
			pend_q <= 1'b0;
			arm_q <= 1'b0;
			mask_q <= 4'h0;
			fire_q <= `SQD_FIRE_RST;
		end else begin
			reply_q <= reply_d;
			diag_cmd_q <= diag_cmd_d;
			diag_act_q <= diag_act_d;
			pend_q <= pend_d;
			arm_q <= arm_d;
			mask_q <= mask_d;
			fire_q <= fire_d;
		end
	end

	assign lk_if.reply = reply_q;
	assign diag_cmd = diag_cmd_q;
	assign diag_active = diag_act_q;
	assign squib_fire = fire_q;

	a_echo_reply: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && lk_if.rx == `SQD_CMD_ECHO
		|=> reply_q == `SQD_ECHO_REPLY)
		else $error("echo reply not 69");

	a_nop_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && lk_if.rx == `SQD_CMD_NOP
		|=> !diag_act_q && reply_q == 8'h00)
		else $error("no-op left a diagnostic active");

	a_bad_length: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && !frame_ok && !pend_q
		|=> $stable(reply_q) && $stable(fire_q) && $stable(diag_act_q))
		else $error("bad length frame executed");

	a_fire_blocked: assert property (@(posedge ref_clk) disable iff (!rstn)
		fire_q != 4'h0 |=> $stable(fire_q))
		else $error("fire changed while firing");

	a_seq_needed: assert property (@(posedge ref_clk) disable iff (!rstn)
		!arm_q |=> $stable(fire_q))
		else $error("fire without preceding arm");

	a_only_at_end: assert property (@(posedge ref_clk) disable iff (!rstn)
		!frame_end |=> $stable(diag_act_q) && $stable(arm_q))
		else $error("command acted before chip select rise");

	a_id_strap: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && lk_if.rx == `SQD_CMD_ID
		|=> reply_q == {TWO_CHANNEL, 7'h00})
		else $error("identity reply wrong");

	a_cont_reply: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && lk_if.rx == `SQD_CMD_CONT
		|=> reply_q == {4'h0, $past(low_side_cont_in)} ##1 diag_act_q)
		else $error("continuity reply wrong");

	a_undef_nop: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls == SQD_CLS_NOP
		|=> !diag_act_q && reply_q == `SQD_REPLY_RST && $stable(fire_q))
		else $error("no-op or undefined code changed state");

	a_diag_held: assert property (@(posedge ref_clk) disable iff (!rstn)
		!frame_end |=> $stable(diag_cmd_q))
		else $error("diagnostic code changed outside frame end");

	a_diag_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls == SQD_CLS_DIAG
		|=> diag_act_q && diag_cmd_q == $past(lk_if.rx) && pend_q)
		else $error("diagnostic command not taken");

	a_cont_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls != SQD_CLS_CONT
		|=> diag_cmd_q != `SQD_CMD_CONT)
		else $error("continuity mode outlived the next frame");

	a_bad_keeps: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && !frame_ok
		|=> $stable(diag_cmd_q) && $stable(mask_q) && $stable(fire_q))
		else $error("bad length frame changed a mode");

	a_bad_no_arm: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && !frame_ok |=> !arm_q)
		else $error("bad length frame kept an arm pending");

	a_arm_echo: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls == SQD_CLS_ARM
		|=> arm_q && !diag_act_q && reply_q == $past(lk_if.rx))
		else $error("arm byte not taken or not echoed");

	a_fire_armed: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls == SQD_CLS_FIRE
		|=> (fire_q & $past(mask_q)) == ($past(lk_if.rx[3:0]) & $past(mask_q)))
		else $error("armed drivers not set from fire byte");

	a_fire_others: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls == SQD_CLS_FIRE
		|=> (fire_q & ~$past(mask_q)) == ($past(fire_q) & ~$past(mask_q)))
		else $error("unarmed drivers changed");

	a_arm_drops: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && !(frame_ok && cls == SQD_CLS_ARM) |=> !arm_q)
		else $error("arm survived a following frame");

	a_mask_held: assert property (@(posedge ref_clk) disable iff (!rstn)
		!frame_end |=> $stable(mask_q))
		else $error("arm mask changed outside frame end");

	a_fire_at_end: assert property (@(posedge ref_clk) disable iff (!rstn)
		!frame_end |=> $stable(fire_q))
		else $error("drivers changed outside frame end");

	a_reply_frozen: assert property (@(posedge ref_clk) disable iff (!rstn)
		!cs_lvl_q && !frame_end |=> $stable(reply_q))
		else $error("reply changed while selected");

	a_sync_agree: assert property (@(posedge ref_clk) disable iff (!rstn)
		$changed(cs_lvl_q) |-> $past(cs_s_q[1]) == $past(cs_s_q[2]))
		else $error("select level moved without agreement");

	a_act_matches: assert property (@(posedge ref_clk) disable iff (!rstn)
		diag_act_q == (diag_cmd_q != `SQD_CMD_NOP))
		else $error("diagnostic flag and code disagree");

	a_pend_tracks: assert property (@(posedge ref_clk) disable iff (!rstn)
		pend_q && cs_lvl_q |=> reply_q == $past(diag_result_in))
		else $error("pending result not tracked while deselected");

	a_id_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
		frame_end && frame_ok && cls == SQD_CLS_ID |=> !diag_act_q && !pend_q)
		else $error("identity query left a diagnostic active");
endmodule : sqd_core

//--- tb/sqd_master.sv
// serial bus master model for the squib command link
// assumes frames are spaced apart by the bench; clock idles between frames
`timescale 1ns/1ps
module sqd_master (
	output logic serial_clk,
	output logic chip_select_n,
	output logic serial_in_pin,
	input wire logic serial_out_pin
);
	import sqd_pkg::*;
	initial begin
		serial_clk = 1'b0;
		chip_select_n = 1'b1;
		serial_in_pin = 1'b0;
	end
	// alt holds the clock high at select fall; n of 1 to 7 or over 8 breaks framing
	task automatic frame(input sqd_byte_t tx, input int n, input logic alt,
		output sqd_byte_t rx);
		logic [15:0] sh;
		sh = {tx, tx};
		rx = 8'h00;
		serial_clk = alt;
		#40 chip_select_n = 1'b0;
		#40 serial_clk = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in_pin = sh[15 - (i % 16)];
			#40 serial_clk = 1'b1;
			rx = {rx[6:0], serial_out_pin};
			#40 serial_clk = 1'b0;
		end
		#40 chip_select_n = 1'b1;
		// released data line must not keep its last value
		serial_in_pin = ~serial_in_pin;
	endtask : frame
endmodule : sqd_master

//--- tb/squib_spi_command_diag_interface_bench.sv
// self-checking bench for the squib command interpreter
// assumes sqd_master drives the link; results are judged at the core ports
`timescale 1ns/1ps
module squib_spi_command_diag_interface_bench;
	import sqd_pkg::*;
	logic ref_clk, rstn, serial_clk, chip_select_n, serial_in_pin;
	logic serial_out_pin, serial_out_oe, diag_active;
	sqd_nib_t low_side_cont_in, squib_fire;
	sqd_byte_t diag_result_in, diag_cmd, rxb;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	sqd_core dut (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.serial_clk(serial_clk),
		.chip_select_n(chip_select_n),
		.serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe),
		.low_side_cont_in(low_side_cont_in),
		.diag_result_in(diag_result_in),
		.diag_cmd(diag_cmd),
		.diag_active(diag_active),
		.squib_fire(squib_fire)
	);
	sqd_master m (
		.serial_clk(serial_clk),
		.chip_select_n(chip_select_n),
		.serial_in_pin(serial_in_pin),
		.serial_out_pin(serial_out_pin)
	);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one frame, then time for the core to act before the next one
	task automatic xf(input sqd_byte_t tx, input int n = 8,
		input logic alt = 1'b0);
		fork
			m.frame(tx, n, alt, rxb);
			#100 chk("oe selected", {7'h00, serial_out_oe}, 8'h01);
		join
		repeat (8) @(posedge ref_clk);
		#2;
		chk("output enable", {7'h00, serial_out_oe}, 8'h00);
	endtask : xf
	task automatic t_echo();
		xf(8'h96);
		// a short frame must leave the echo reply pending
		xf(8'h00, 7);
		xf(8'h00);
		chk("echo reply", rxb, 8'h69);
		xf(8'h00);
		chk("nop reply", rxb, 8'h00);
		chk("nop mode", {7'h00, diag_active}, 8'h00);
	endtask : t_echo
	task automatic t_id();
		xf(8'hC8, 8, 1'b1);
		xf(8'h96, 8, 1'b1);
		chk("strap reply", rxb, 8'h00);
		xf(8'h00);
		chk("alt echo", rxb, 8'h69);
	endtask : t_id
	task automatic t_cont();
		xf(8'hC2);
		chk("cont cmd", diag_cmd, 8'hC2);
		chk("cont mode", {7'h00, diag_active}, 8'h01);
		xf(8'h00);
		chk("cont reply", rxb, 8'h0A);
		chk("cont cleared", diag_cmd, 8'h00);
		xf(8'h00);
		chk("cont latch", rxb, 8'h00);
	endtask : t_cont
	task automatic t_len();
		xf(8'hD0);
		xf(8'h00, 7);
		xf(8'h00, 9);
		chk("bad length", diag_cmd, 8'hD0);
		xf(8'h11);
		chk("diag reply", rxb, 8'h3C);
		chk("undefined", diag_cmd, 8'h00);
		xf(8'hC1);
		chk("undefined reply", rxb, 8'h00);
		chk("force cmd", diag_cmd, 8'hC1);
		xf(8'hE8);
		chk("sense cmd", diag_cmd, 8'hE8);
	endtask : t_len
	task automatic t_fire();
		xf(8'hA1);
		xf(8'h00);
		xf(8'h5C);
		chk("split arm", {4'h0, squib_fire}, 8'h00);
		xf(8'hA0);
		xf(8'h53);
		chk("arm echo", rxb, 8'hA0);
		chk("fire", {4'h0, squib_fire}, 8'h03);
		xf(8'hA2);
		xf(8'h5F);
		chk("fire busy", {4'h0, squib_fire}, 8'h03);
	endtask : t_fire
	task automatic t_reset();
		xf(8'hD0);
		rstn = 1'b0;
		@(posedge ref_clk);
		#2;
		chk("reset fire", {4'h0, squib_fire}, 8'h00);
		chk("reset cmd", diag_cmd, 8'h00);
		rstn = 1'b1;
		repeat (6) @(posedge ref_clk);
		xf(8'h00);
		chk("reset reply", rxb, 8'h00);
	endtask : t_reset
	initial begin
		rstn = 1'b0;
		low_side_cont_in = 4'hA;
		diag_result_in = 8'h3C;
		repeat (12) @(posedge ref_clk);
		#2 rstn = 1'b1;
		repeat (6) @(posedge ref_clk);
		t_echo();
		t_id();
		t_cont();
		t_len();
		t_fire();
		t_reset();
		complete_run();
	end
endmodule : squib_spi_command_diag_interface_bench
